// ### hdl/tpam_aux_mux.v
`include "tpam_regs.vh"
`default_nettype none

// One auxiliary pin: digital driver plus analog switch control
module tpam_aux_mux (
	// Clock and reset
	input  wire       clk,
	input  wire       sys_rst,
	// Source selector
	input  wire [3:0] source_select,
	// Digital sources, all in the clk domain
	input  wire       sam_clock,
	input  wire       transmit_active_flag,
	input  wire       receive_active_flag,
	input  wire       subcarrier_detected,
	input  wire       testbus_bit,
	// Pin drive and analog switch
	output reg        pin_out,
	output reg        pin_oe_n,
	output reg        analog_connect
);

	// Decode the selector into a registered pin state
	always @(posedge clk) begin
		if (sys_rst) begin
			pin_out        <= 1'b0;
			pin_oe_n       <= 1'b1;
			analog_connect <= 1'b0;
		end else begin
			case (source_select)
				`TPAM_SEL_TRISTATE: begin // [R9]
					pin_out        <= 1'b0;
					pin_oe_n       <= 1'b1;
					analog_connect <= 1'b0;
				end
				// Current-mode sources: digital driver must let go
				`TPAM_SEL_DAC, `TPAM_SEL_CORRELATOR_SIGNAL_ONE, `TPAM_SEL_CORRELATOR_SIGNAL_TWO,
				`TPAM_SEL_MIN_LEVEL, `TPAM_SEL_ADC_I, `TPAM_SEL_ADC_Q,
				`TPAM_SEL_PROD_A, `TPAM_SEL_PROD_B: begin // [R9] [R10] [R11]
					pin_out        <= 1'b0;
					pin_oe_n       <= 1'b1;
					analog_connect <= 1'b1;
				end
				`TPAM_SEL_SAM_CLOCK: begin // [R12]
					pin_out        <= sam_clock;
					pin_oe_n       <= 1'b0;
					analog_connect <= 1'b0;
				end
				`TPAM_SEL_HIGH: begin // [R12]
					pin_out        <= 1'b1;
					pin_oe_n       <= 1'b0;
					analog_connect <= 1'b0;
				end
				`TPAM_SEL_LOW: begin // [R12]
					pin_out        <= 1'b0;
					pin_oe_n       <= 1'b0;
					analog_connect <= 1'b0;
				end
				`TPAM_SEL_TX_ACTIVE: begin // [R13]
					pin_out        <= transmit_active_flag;
					pin_oe_n       <= 1'b0;
					analog_connect <= 1'b0;
				end
				`TPAM_SEL_RX_ACTIVE: begin // [R14]
					pin_out        <= receive_active_flag;
					pin_oe_n       <= 1'b0;
					analog_connect <= 1'b0;
				end
				`TPAM_SEL_SUBCARRIER: begin // [R15]
					pin_out        <= subcarrier_detected;
					pin_oe_n       <= 1'b0;
					analog_connect <= 1'b0;
				end
				`TPAM_SEL_TESTBUS_BIT: begin // [R16]
					pin_out        <= testbus_bit;
					pin_oe_n       <= 1'b0;
					analog_connect <= 1'b0;
				end
				default: begin
					pin_out        <= 1'b0;
					pin_oe_n       <= 1'b1;
					analog_connect <= 1'b0;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

// ### hdl/tpam_sync2.v
`default_nettype none

// Two-stage synchroniser for levels from outside the clk domain
module tpam_sync2 #(
	parameter WIDTH = 1
) (
	// Clock and reset
	input  wire             clk,
	input  wire             sys_rst,
	// Asynchronous level in, synchronised level out
	input  wire [WIDTH-1:0] async_in,
	output reg  [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta;

	// First stage feeds only the second stage
	always @(posedge clk) begin
		if (sys_rst) begin
			meta     <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end

endmodule

`default_nettype wire

// ### hdl/tpam_test_page.v
// What this block does
// R1: Code 1001 in bits 3:0 arms self test
// R2: Host writes 0000 for normal operation
// R3: Bit 6 set selects non-linear receive processing
// R4: Thresholds also act non-linearly in that mode
// R5: Host writes bit 5 zero, ignores 4, 7
// R6: Self-test control resets to 40h
// R7: Read-only version register, writes ignored
// R8: Aux select resets 00h; 7:4 aux_pin_one, 3:0 aux_pin_two
// R9: 0000 tristate, 0001 routes matching test DAC
// R10: Codes 0010-0110 route correlator, level, converter signals
// R11: Codes 0111, 1000 route production test signals
// R12: 1001 secure clock, 1010 high, 1011 low
// R13: Code 1100 drives transmit-active flag
// R14: Code 1101 drives receive-active flag
// R15: Code 1110 drives subcarrier-detected flag
// R16: Code 1111 drives selected test-bus bit
// R17: DAC1 value bits 5:0, shown via aux_pin_one 0001
// R18: DAC1 bits 7, 6 have no function
// R19: Bit-select field picks one test-bus line
// R20: Reserved bits read zero, writes harmless
`include "tpam_regs.vh"
`default_nettype none

module tpam_test_page #(
	parameter [7:0] VERSION_CODE = 8'hA5, // Arbitrary value
	parameter       TESTBUS_W    = 8
) (
	// Clock and reset
	input  wire                      clk,
	input  wire                      sys_rst,
	// Register access port
	input  wire [`TPAM_ADDR_W-1:0]   reg_addr,
	input  wire                      reg_wr,
	input  wire [7:0]                reg_wdata,
	input  wire                      reg_rd,
	output reg  [7:0]                reg_rdata,
	output reg                       reg_rvalid,
	// Command strobe from the command decoder
	input  wire                      crc_calculate_command,
	// Internal test sources (clk domain)
	input  wire                      transmit_active_flag,
	input  wire                      receive_active_flag,
	input  wire                      subcarrier_detected,
	input  wire [TESTBUS_W-1:0]      testbus,
	input  wire [2:0]                testbus_bit_select,
	// Secure-module clock, foreign domain
	input  wire                      sam_clock,
	// Self-test and receiver controls
	output reg                       self_test_armed,
	output reg                       self_test_start,
	output reg                       receiver_nonlinear_enable,
	output reg                       threshold_nonlinear_enable,
	// Test DAC value
	output reg  [5:0]                test_dac1_value,
	// First auxiliary pin
	output wire                      aux_pin_one_out,
	output wire                      aux_pin_one_oe_n,
	output wire                      aux_pin_one_analog,
	output reg  [3:0]                aux_pin_one_route,
	// Second auxiliary pin
	output wire                      aux_pin_two_out,
	output wire                      aux_pin_two_oe_n,
	output wire                      aux_pin_two_analog,
	output reg  [3:0]                aux_pin_two_route
);

	// Reset images, named so single fields can be picked out of them
	localparam [7:0] RST_SELF = `TPAM_RST_SELF_TEST;
	localparam [7:0] RST_AUX  = `TPAM_RST_AUX_SELECT;

	// Stored register fields
	reg  [3:0] self_test_code;
	reg        nonlinear_bit;
	reg  [3:0] aux_pin_one_source_select;
	reg  [3:0] aux_pin_two_source_select;
	reg  [5:0] dac1_field;

	// Derived signals
	wire       sam_clock_sync;
	reg        testbus_bit;
	reg  [7:0] next_rdata;
	wire       wr_self_test;
	wire       wr_aux_select;
	wire       wr_dac1;

	// Write decode; the version offset has no write path at all
	assign wr_self_test  = reg_wr && (reg_addr == `TPAM_ADDR_SELF_TEST);
	assign wr_aux_select = reg_wr && (reg_addr == `TPAM_ADDR_AUX_SELECT);
	assign wr_dac1       = reg_wr && (reg_addr == `TPAM_ADDR_DAC1); // [R7]

	// Register writes; reserved bits are simply not stored
	always @(posedge clk) begin
		if (sys_rst) begin
			self_test_code     <= RST_SELF[`TPAM_ST_CODE_HI:`TPAM_ST_CODE_LO]; // [R6]
			nonlinear_bit      <= RST_SELF[`TPAM_ST_NONLIN_BIT]; // [R6]
			aux_pin_one_source_select <= RST_AUX[`TPAM_AUX_PIN_ONE_HI:`TPAM_AUX_PIN_ONE_LO]; // [R8]
			aux_pin_two_source_select <= RST_AUX[`TPAM_AUX_PIN_TWO_HI:`TPAM_AUX_PIN_TWO_LO]; // [R8]
			dac1_field         <= `TPAM_RST_DAC1;
		end else begin
			if (wr_self_test) begin
				// Bits 7, 5 and 4 are dropped so they cannot steer anything
				self_test_code <= reg_wdata[`TPAM_ST_CODE_HI:`TPAM_ST_CODE_LO]; // [R1] [R20]
				nonlinear_bit  <= reg_wdata[`TPAM_ST_NONLIN_BIT]; // [R3]
			end
			if (wr_aux_select) begin
				aux_pin_one_source_select <= reg_wdata[`TPAM_AUX_PIN_ONE_HI:`TPAM_AUX_PIN_ONE_LO]; // [R8]
				aux_pin_two_source_select <= reg_wdata[`TPAM_AUX_PIN_TWO_HI:`TPAM_AUX_PIN_TWO_LO]; // [R8]
			end
			if (wr_dac1) begin
				dac1_field <= reg_wdata[`TPAM_DAC_HI:`TPAM_DAC_LO]; // [R17] [R18]
			end
		end
	end

	// Read mux; reserved and production bits always come back zero
	always @* begin
		next_rdata = `TPAM_RST_READ;
		case (reg_addr)
			`TPAM_ADDR_SELF_TEST: begin
				next_rdata[`TPAM_ST_NONLIN_BIT]              = nonlinear_bit;
				next_rdata[`TPAM_ST_CODE_HI:`TPAM_ST_CODE_LO] = self_test_code; // [R20]
			end
			`TPAM_ADDR_VERSION: begin
				next_rdata = VERSION_CODE; // [R7]
			end
			`TPAM_ADDR_AUX_SELECT: begin
				next_rdata = {aux_pin_one_source_select, aux_pin_two_source_select};
			end
			`TPAM_ADDR_DAC1: begin
				next_rdata[`TPAM_DAC_HI:`TPAM_DAC_LO] = dac1_field; // [R18] [R20]
			end
			default: begin
				next_rdata = `TPAM_RST_READ;
			end
		endcase
	end

	// Read data registered so the port is glitch free
	always @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata  <= `TPAM_RST_READ;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= next_rdata;
			end
		end
	end

	// Self-test arming and start; any code but the arm code leaves it off
	always @(posedge clk) begin
		if (sys_rst) begin
			self_test_armed <= 1'b0;
			self_test_start <= 1'b0;
		end else begin
			self_test_armed <= (self_test_code == `TPAM_ST_CODE_ARM); // [R1] [R2]
			self_test_start <= crc_calculate_command &&
				(self_test_code == `TPAM_ST_CODE_ARM); // [R1]
		end
	end

	// Receive chain and threshold mode follow the same bit together
	always @(posedge clk) begin
		if (sys_rst) begin
			receiver_nonlinear_enable  <= 1'b0;
			threshold_nonlinear_enable <= 1'b0;
		end else begin
			receiver_nonlinear_enable  <= nonlinear_bit; // [R3]
			threshold_nonlinear_enable <= nonlinear_bit; // [R4]
		end
	end

	// DAC value and analog routes mirrored into output flops
	always @(posedge clk) begin
		if (sys_rst) begin
			test_dac1_value   <= `TPAM_RST_DAC1;
			aux_pin_one_route <= `TPAM_SEL_TRISTATE;
			aux_pin_two_route <= `TPAM_SEL_TRISTATE;
		end else begin
			test_dac1_value   <= dac1_field; // [R17]
			aux_pin_one_route <= aux_pin_one_source_select; // [R9] [R10]
			aux_pin_two_route <= aux_pin_two_source_select; // [R9] [R10]
		end
	end

	// Test-bus bit pick, one cycle early to match the selector path
	always @(posedge clk) begin
		if (sys_rst) begin
			testbus_bit <= 1'b0;
		end else begin
			testbus_bit <= testbus[testbus_bit_select]; // [R19]
		end
	end

	// Secure clock comes from another domain; sampled, so it jitters by one clk
	tpam_sync2 #(
		.WIDTH (1)
	) u_sam_sync (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.async_in (sam_clock),
		.sync_out (sam_clock_sync)
	);

	// First auxiliary pin
	tpam_aux_mux u_aux_one (
		.clk                  (clk),
		.sys_rst              (sys_rst),
		.source_select        (aux_pin_one_source_select),
		.sam_clock            (sam_clock_sync),
		.transmit_active_flag (transmit_active_flag),
		.receive_active_flag  (receive_active_flag),
		.subcarrier_detected  (subcarrier_detected),
		.testbus_bit          (testbus_bit),
		.pin_out              (aux_pin_one_out),
		.pin_oe_n             (aux_pin_one_oe_n),
		.analog_connect       (aux_pin_one_analog)
	);

	// Second auxiliary pin, same code table
	tpam_aux_mux u_aux_two (
		.clk                  (clk),
		.sys_rst              (sys_rst),
		.source_select        (aux_pin_two_source_select),
		.sam_clock            (sam_clock_sync),
		.transmit_active_flag (transmit_active_flag),
		.receive_active_flag  (receive_active_flag),
		.subcarrier_detected  (subcarrier_detected),
		.testbus_bit          (testbus_bit),
		.pin_out              (aux_pin_two_out),
		.pin_oe_n             (aux_pin_two_oe_n),
		.analog_connect       (aux_pin_two_analog)
	);

endmodule

`default_nettype wire

// ### shared/tpam_regs.vh
`ifndef TPAM_REGS_VH
`define TPAM_REGS_VH

// Register page offsets
`define TPAM_ADDR_W            6
`define TPAM_ADDR_SELF_TEST    6'h36
`define TPAM_ADDR_VERSION      6'h37
`define TPAM_ADDR_AUX_SELECT   6'h38
`define TPAM_ADDR_DAC1         6'h39

// Reset values
`define TPAM_RST_SELF_TEST     8'h40
`define TPAM_RST_AUX_SELECT    8'h00
`define TPAM_RST_DAC1          6'h00
`define TPAM_RST_READ          8'h00

// Self-test control fields
`define TPAM_ST_CODE_HI        3
`define TPAM_ST_CODE_LO        0
`define TPAM_ST_NONLIN_BIT     6
`define TPAM_ST_CODE_ARM       4'h9
`define TPAM_ST_CODE_OFF       4'h0

// Aux select fields
`define TPAM_AUX_PIN_ONE_HI           7
`define TPAM_AUX_PIN_ONE_LO           4
`define TPAM_AUX_PIN_TWO_HI           3
`define TPAM_AUX_PIN_TWO_LO           0

// DAC1 value field
`define TPAM_DAC_HI            5
`define TPAM_DAC_LO            0

// Aux source codes
`define TPAM_SEL_TRISTATE      4'h0
`define TPAM_SEL_DAC           4'h1
`define TPAM_SEL_CORRELATOR_SIGNAL_ONE         4'h2
`define TPAM_SEL_CORRELATOR_SIGNAL_TWO         4'h3
`define TPAM_SEL_MIN_LEVEL     4'h4
`define TPAM_SEL_ADC_I         4'h5
`define TPAM_SEL_ADC_Q         4'h6
`define TPAM_SEL_PROD_A        4'h7
`define TPAM_SEL_PROD_B        4'h8
`define TPAM_SEL_SAM_CLOCK     4'h9
`define TPAM_SEL_HIGH          4'hA
`define TPAM_SEL_LOW           4'hB
`define TPAM_SEL_TX_ACTIVE     4'hC
`define TPAM_SEL_RX_ACTIVE     4'hD
`define TPAM_SEL_SUBCARRIER    4'hE
`define TPAM_SEL_TESTBUS_BIT   4'hF

`endif

// ### tb/tpam_aux_probe.sv
`default_nettype none
// Bench instrument on one aux pin, with the recommended pull-down
module tpam_aux_probe (
	// Pin as the block drives it
	input  wire logic pin_out,
	input  wire logic pin_oe_n,
	// Level the instrument sees
	output wire logic level
);
	timeunit 1ns;
	timeprecision 1ps;
	// A released pin sinks to the pull-down level, never the last value
	assign level = pin_oe_n ? 1'b0 : pin_out;
endmodule
`default_nettype wire

// ### tb/tpam_test_page_properties.sv
`default_nettype none
// Port-level checks of the test page
module tpam_test_page_checker #(
	parameter [7:0] VERSION_CODE = 8'hA5
) (
	// Clock and reset
	input wire logic       clk,
	input wire logic       sys_rst,
	// Register port
	input wire logic [5:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_rvalid,
	// Self test and receiver
	input wire logic       crc_calculate_command,
	input wire logic       transmit_active_flag,
	input wire logic       self_test_armed,
	input wire logic       self_test_start,
	input wire logic       receiver_nonlinear_enable,
	input wire logic [5:0] test_dac1_value,
	// Aux pins
	input wire logic       aux_pin_one_out,
	input wire logic       aux_pin_one_oe_n,
	input wire logic       aux_pin_one_analog,
	input wire logic [3:0] aux_pin_one_route,
	input wire logic       aux_pin_two_out,
	input wire logic       aux_pin_two_oe_n,
	input wire logic       aux_pin_two_analog,
	input wire logic [3:0] aux_pin_two_route
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	version_read_a: assert property (reg_rd && reg_addr == 6'h37 |=>
		reg_rvalid && reg_rdata == VERSION_CODE) else $error("version read wrong");
	unmapped_read_a: assert property (reg_rd && reg_addr < 6'h36 |=>
		reg_rdata == 8'h00) else $error("unmapped read not zero");
	self_test_arm_a: assert property (reg_wr && reg_addr == 6'h36 &&
		reg_wdata[3:0] == 4'h9 |-> ##2 self_test_armed) else $error("not armed");
	start_cause_a: assert property (self_test_start |->
		$past(crc_calculate_command)) else $error("start without command");
	start_armed_a: assert property (crc_calculate_command && self_test_armed &&
		!$past(reg_wr) |=> self_test_start) else $error("armed command lost");
	nonlin_write_a: assert property (reg_wr && reg_addr == 6'h36 |-> ##2
		receiver_nonlinear_enable == $past(reg_wdata[6], 2)) else $error("nonlinear bit");
	dac_store_a: assert property (reg_wr && reg_addr == 6'h39 |-> ##2
		test_dac1_value == $past(reg_wdata[5:0], 2)) else $error("dac value not stored");
	aux_tristate_a: assert property (aux_pin_one_route == 4'h0 |-> aux_pin_one_oe_n &&
		!aux_pin_one_analog && !aux_pin_one_out) else $error("aux one not tristate");
	aux_analog_a: assert property (aux_pin_two_route inside {[4'h1:4'h8]} |->
		aux_pin_two_oe_n && aux_pin_two_analog) else $error("aux two not analog");
	aux_high_a: assert property (aux_pin_two_route == 4'hA |->
		!aux_pin_two_oe_n && aux_pin_two_out) else $error("aux two not high");
	aux_tx_a: assert property (aux_pin_one_route == 4'hC |-> !aux_pin_one_oe_n &&
		aux_pin_one_out == $past(transmit_active_flag)) else $error("aux one not tx");
	// Main scenarios reached
	cover property (self_test_start);
	cover property (aux_pin_one_route == 4'hF && !aux_pin_one_oe_n);
	cover property (reg_rvalid && reg_rdata == VERSION_CODE);
endmodule
bind tpam_test_page tpam_test_page_checker #(.VERSION_CODE(VERSION_CODE)) chk (.*);
`default_nettype wire

// ### tb/tpam_test_page_test.sv
`default_nettype none
module tpam_test_page_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam [7:0] VER = 8'h5C; // Arbitrary value
	logic       clk, sys_rst, reg_wr, reg_rd, crc, tx, rx, sub, sam;
	logic [5:0] reg_addr;
	logic [7:0] reg_wdata, tb;
	logic [2:0] sel;
	wire  [7:0] rdata;
	wire  [5:0] dac;
	wire  [3:0] rt1, rt2;
	wire        rvalid, armed, start, nl_rx, nl_th, o1, e1, a1, o2, e2, a2, lv1, lv2;
	int         errors, num_checks;

	tpam_test_page #(.VERSION_CODE(VER), .TESTBUS_W(8)) dut (
		.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(rdata), .reg_rvalid(rvalid),
		.crc_calculate_command(crc), .transmit_active_flag(tx), .receive_active_flag(rx),
		.subcarrier_detected(sub), .testbus(tb), .testbus_bit_select(sel), .sam_clock(sam),
		.self_test_armed(armed), .self_test_start(start), .receiver_nonlinear_enable(nl_rx),
		.threshold_nonlinear_enable(nl_th), .test_dac1_value(dac),
		.aux_pin_one_out(o1), .aux_pin_one_oe_n(e1), .aux_pin_one_analog(a1),
		.aux_pin_one_route(rt1), .aux_pin_two_out(o2), .aux_pin_two_oe_n(e2),
		.aux_pin_two_analog(a2), .aux_pin_two_route(rt2));
	tpam_aux_probe p1 (.pin_out(o1), .pin_oe_n(e1), .level(lv1));
	tpam_aux_probe p2 (.pin_out(o2), .pin_oe_n(e2), .level(lv2));

	// Free-running 125 MHz clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Strobe drops after its edge, then one idle edge before the next call
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk);
		#1 reg_wr = 1'b0;
		@(posedge clk);
		#1;
	endtask

	task automatic rd(input logic [5:0] a, input logic [7:0] exp);
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#1 reg_rd = 1'b0;
		check({7'h00, rvalid}, 8'h01);
		check(rdata, exp);
		@(posedge clk);
		#1;
	endtask

	task automatic pulse_cmd;
		crc = 1'b1;
		@(posedge clk);
		#1 crc = 1'b0;
	endtask

	// Pin level the instrument should see for one source code
	function automatic logic lvl(input logic [3:0] c);
		case (c)
			4'h9: lvl = sam;
			4'hA: lvl = 1'b1;
			4'hC: lvl = tx;
			4'hD: lvl = rx;
			4'hE: lvl = sub;
			4'hF: lvl = tb[sel];
			default: lvl = 1'b0;
		endcase
	endfunction

	task automatic t_reset;
		check({6'h00, e1, e2}, 8'h03);
		rd(6'h36, 8'h40);
		rd(6'h38, 8'h00);
		rd(6'h37, VER);
		check({7'h00, nl_rx}, 8'h01);
		check({7'h00, armed}, 8'h00);
	endtask

	task automatic t_regs;
		wr(6'h36, 8'hDF);
		rd(6'h36, 8'h4F);
		wr(6'h36, 8'h40);
		wr(6'h37, 8'h00);
		rd(6'h37, VER);
		wr(6'h39, 8'hFF);
		rd(6'h39, 8'h3F);
		check({2'b00, dac}, 8'h3F);
		wr(6'h39, 8'hD5);
		rd(6'h39, 8'h15);
		wr(6'h3A, 8'hFF);
		rd(6'h3A, 8'h00);
	endtask

	task automatic t_self;
		wr(6'h36, 8'h09);
		pulse_cmd();
		check({7'h00, start}, 8'h01);
		@(posedge clk);
		#1 check({6'h00, start, armed}, 8'h01);
		pulse_cmd();
		check({7'h00, start}, 8'h01);
		wr(6'h36, 8'h00);
		pulse_cmd();
		check({7'h00, start}, 8'h00);
		check({6'h00, nl_rx, nl_th}, 8'h00);
		wr(6'h36, 8'h40);
		@(posedge clk);
		#1 check({6'h00, nl_rx, nl_th}, 8'h03);
	endtask

	// Every code on both pins, sources flipped between rounds
	task automatic t_aux(input logic p);
		{tx, rx, sub, sam} = p ? 4'h5 : 4'hA;
		sel = p ? 3'h2 : 3'h3;
		tb = 8'h5A;
		for (int c = 0; c < 16; c++) begin
			wr(6'h38, {c[3:0], ~c[3:0]});
			repeat (3) @(posedge clk);
			#1 check({rt1, rt2}, {c[3:0], ~c[3:0]});
			check({6'h00, lv1, lv2}, {6'h00, lvl(c[3:0]), lvl(~c[3:0])});
			check({6'h00, a1, a2}, {6'h00, c >= 1 && c <= 8, c >= 7 && c <= 14});
		end
	endtask

	task automatic test_done;
		$display("Checks %0d, errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Main sequence
	initial begin
		{sys_rst, reg_wr, reg_rd, crc, tx, rx, sub, sam} = 8'h80;
		{reg_addr, reg_wdata, tb, sel} = 25'h0;
		errors = 0;
		num_checks = 0;
		repeat (20) @(posedge clk);
		#1 sys_rst = 1'b0;
		t_reset();
		t_regs();
		t_self();
		t_aux(1'b0);
		t_aux(1'b1);
		test_done();
	end

	// Hang guard, well past the expected run
	initial begin
		#200000;
		errors++;
		test_done();
	end
endmodule
`default_nettype wire
